// File: rtl/branch_unit_params.svh
// Offsets, field positions, reset values and widths for the branch and bit-clear unit.
`ifndef BRANCH_UNIT_PARAMS_SVH
`define BRANCH_UNIT_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define CTRL_OFF 4'h0
`define STATUS_OFF 4'h4
`define TAKEN_CNT_OFF 4'h8
`define LAST_PC_OFF 4'hc

// Control register field positions and reset value.
`define CTRL_SHORT_REG_BIT 0
`define CTRL_RST 1'b0

// Status register field positions.
`define STAT_BUSY_BIT 0
`define STAT_TAKEN_BIT 1
`define STAT_GFLAG_BIT 2
`define STAT_UNSUP_BIT 3

// AXI response codes.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Program counter width and the widened sum width for 25-bit displacements.
`define PC_W 24
`define SUM_W 25
`define WORD_W 16
`define BYTE_W 8

`endif

// File: rtl/branch_unit_pkg.sv
// Types shared by the branch and bit-clear unit and its condition evaluator.
package branch_unit_pkg;

	// Kind of instruction handed over by decode.
	typedef enum logic [1:0] {
		OP_BRANCH_COND = 2'h0,
		OP_BRANCH_ALWAYS = 2'h1,
		OP_BRANCH_ZERO = 2'h2,
		OP_BIT_CLEAR = 2'h3
	} op_e;

	// Condition codes; code 4'hf is unused and evaluates false.
	typedef enum logic [3:0] {
		COND_EQUAL = 4'h0,
		COND_NOT_EQUAL = 4'h1,
		COND_CARRY_SET = 4'h2,
		COND_CARRY_CLEAR = 4'h3,
		COND_HIGHER = 4'h4,
		COND_LOWER_SAME = 4'h5,
		COND_GREATER = 4'h6,
		COND_LESS_EQUAL = 4'h7,
		COND_FLAG_SET = 4'h8,
		COND_FLAG_CLEAR = 4'h9,
		COND_LOWER = 4'ha,
		COND_HIGHER_SAME = 4'hb,
		COND_LESS = 4'hc,
		COND_GREATER_EQUAL = 4'hd,
		COND_ALWAYS = 4'he
	} cond_e;

	// Encoded displacement formats of the relative branches.
	typedef enum logic [1:0] {
		DISP_9 = 2'h0,
		DISP_17 = 2'h1,
		DISP_25 = 2'h2
	} disp_e;

	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} state_e;

	// Status word flags as seen by this unit.
	typedef struct packed {
		logic zeroFlag;
		logic carryFlag;
		logic lowFlag;
		logic negativeFlag;
		logic generalFlag;
	} flags_s;

	// One decoded instruction.
	typedef struct packed {
		op_e op;
		cond_e cond;
		disp_e dispSize;
		logic [23:0] dispField;
		logic [3:0] zeroDispField;
		logic zeroEqForm;
		logic isByte;
		logic [15:0] regVal;
		logic [3:0] bitPos;
		logic [23:0] memAddr;
		logic regPairTarget;
		logic [23:0] pc;
		logic [2:0] instLen;
	} instr_s;

	// Completion report toward the program counter and status word.
	typedef struct packed {
		logic valid;
		logic taken;
		logic [23:0] pcNext;
		logic generalFlagWe;
		logic generalFlag;
		logic unsupported;
	} result_s;

	// Memory access request.
	typedef struct packed {
		logic valid;
		logic write;
		logic byteOp;
		logic [23:0] addr;
		logic [15:0] wdata;
	} mem_req_s;

	// Whole state of the unit.
	typedef struct packed {
		state_e st;
		logic [23:0] addr;
		logic [15:0] data;
		logic isByte;
		logic [3:0] pos;
		logic [23:0] seqPc;
		result_s res;
		logic shortRegMode;
		logic lastTaken;
		logic lastUnsup;
		logic [15:0] takenCnt;
		logic awHave;
		logic [3:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} unit_state_s;

endpackage

// File: rtl/cond_eval.sv
// Condition code evaluator for the conditional branches.
`timescale 1ns/1ns
module cond_eval (
	input branch_unit_pkg::cond_e cond,
	input branch_unit_pkg::flags_s flags,
	output logic condTrue
);

	// Each code except always and the unused 4'hf looks at one flag, or at a pair of flags for the combined tests.
	always_comb begin
		unique case (cond)
			branch_unit_pkg::COND_EQUAL: condTrue = flags.zeroFlag;
			branch_unit_pkg::COND_NOT_EQUAL: condTrue = !flags.zeroFlag;
			branch_unit_pkg::COND_CARRY_SET: condTrue = flags.carryFlag;
			branch_unit_pkg::COND_CARRY_CLEAR: condTrue = !flags.carryFlag;
			branch_unit_pkg::COND_HIGHER: condTrue = flags.lowFlag;
			branch_unit_pkg::COND_LOWER_SAME: condTrue = !flags.lowFlag;
			branch_unit_pkg::COND_GREATER: condTrue = flags.negativeFlag;
			branch_unit_pkg::COND_LESS_EQUAL: condTrue = !flags.negativeFlag;
			branch_unit_pkg::COND_FLAG_SET: condTrue = flags.generalFlag;
			branch_unit_pkg::COND_FLAG_CLEAR: condTrue = !flags.generalFlag;
			branch_unit_pkg::COND_LOWER: condTrue = !flags.zeroFlag && !flags.lowFlag;
			branch_unit_pkg::COND_HIGHER_SAME: condTrue = flags.zeroFlag || flags.lowFlag;
			branch_unit_pkg::COND_LESS: condTrue = !flags.zeroFlag && !flags.negativeFlag;
			branch_unit_pkg::COND_GREATER_EQUAL: condTrue = flags.zeroFlag || flags.negativeFlag;
			branch_unit_pkg::COND_ALWAYS: condTrue = 1'b1;
			default: condTrue = 1'b0;
		endcase
	end

endmodule

// File: rtl/branch_condition_bit_clear_unit.sv
// Execution unit for relative branches, compare-to-zero branches and the memory bit clear.
//
// Behaviour
// - Single-flag condition codes test one flag.
// - Less-equal: negative clear; less: zero and negative clear.
// - Greater-equal and higher-same: either flag set.
// - Lower taken only when zero and low clear.
// - Branch displacement is encoded field times two.
// - Taken branch adds 25-bit sign-extended displacement.
// - Unconditional branch is a condition always true.
// - False condition advances to next sequential instruction.
// - Zero-compare branch: equal or not-equal to zero.
// - Zero compare is byte or word wide.
// - Zero-compare offset is unsigned, even, 2 to 32.
// - Zero-compare branch only goes forward.
// - Zero-compare offset is field plus one, doubled.
// - Bit clear is one locked read-modify-write.
// - Bit position 0-7 byte, 0-15 word.
// - Original bit value goes to general flag.
// - Register-pair bit clear unsupported in short mode off.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "branch_unit_params.svh"
module branch_condition_bit_clear_unit #(
	parameter int ADDR_W = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input branch_unit_pkg::instr_s instr,
	input wire logic instrValid,
	output logic instrReady,
	input branch_unit_pkg::flags_s flags,
	output branch_unit_pkg::result_s result,
	output branch_unit_pkg::mem_req_s memReq,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	output logic rmwLock
);

	// Register selector shared by the read and write paths.
	typedef enum logic [2:0] {
		SEL_CTRL = 3'h0,
		SEL_STATUS = 3'h1,
		SEL_TAKEN_CNT = 3'h2,
		SEL_LAST_PC = 3'h3,
		SEL_NONE = 3'h4
	} sel_t;

	branch_unit_pkg::unit_state_s s_r;
	branch_unit_pkg::unit_state_s s_nxt;
	logic condTrue;
	logic [`SUM_W-1:0] branchDisp;
	logic [`PC_W-1:0] branchTarget;
	logic [5:0] zeroOffset;
	logic [`PC_W-1:0] zeroTarget;
	logic [`PC_W-1:0] seqPc;
	logic operandZero;
	logic zeroTaken;
	logic [`WORD_W-1:0] clearMask;
	logic origBit;
	logic accept;

	// Maps a byte address onto a register; anything off the map answers with an error.
	function automatic sel_t decodeAddr(input logic [ADDR_W-1:0] a);
		logic [3:0] off;
		off = 4'(a);
		unique case (off)
			`CTRL_OFF: decodeAddr = SEL_CTRL;
			`STATUS_OFF: decodeAddr = SEL_STATUS;
			`TAKEN_CNT_OFF: decodeAddr = SEL_TAKEN_CNT;
			`LAST_PC_OFF: decodeAddr = SEL_LAST_PC;
			default: decodeAddr = SEL_NONE;
		endcase
		// Bits above the four-bit map must be clear, otherwise a wider bus would alias the registers.
		if ((a >> 4) != '0) begin
			decodeAddr = SEL_NONE;
		end
	endfunction

	// Rebuilds the byte displacement from the halved field, sign-extended to 25 bits.
	function automatic logic [`SUM_W-1:0] expandDisp(input branch_unit_pkg::disp_e size, input logic [23:0] f);
		unique case (size)
			branch_unit_pkg::DISP_9: expandDisp = {{16{f[7]}}, f[7:0], 1'b0};
			branch_unit_pkg::DISP_17: expandDisp = {{8{f[15]}}, f[15:0], 1'b0};
			branch_unit_pkg::DISP_25: expandDisp = {f[23:0], 1'b0};
			default: expandDisp = {f[23:0], 1'b0};
		endcase
	endfunction

	cond_eval condEval (
		.cond(instr.cond),
		.flags(flags),
		.condTrue(condTrue)
	);

	// Target arithmetic for both branch families; the sum wraps within the 24-bit address space.
	always_comb begin
		branchDisp = expandDisp(instr.dispSize, instr.dispField);
		branchTarget = `PC_W'({1'b0, instr.pc} + branchDisp);
		zeroOffset = {5'({1'b0, instr.zeroDispField} + 5'h01), 1'b0};
		zeroTarget = instr.pc + {18'h00000, zeroOffset};
		seqPc = instr.pc + {21'h000000, instr.instLen};
	end

	// Compare-to-zero: a byte compare looks only at the low eight bits.
	always_comb begin
		if (instr.isByte) begin
			operandZero = (instr.regVal[`BYTE_W-1:0] == 8'h00);
		end else begin
			operandZero = (instr.regVal == 16'h0000);
		end
		zeroTaken = instr.zeroEqForm ? operandZero : !operandZero;
	end

	// Bit selection for the clear. Positions past the operand width clear nothing, since their effect is undefined.
	always_comb begin
		clearMask = 16'h0000;
		if (s_r.isByte) begin
			if (!s_r.pos[3]) begin
				clearMask = 16'h0001 << s_r.pos[2:0];
			end
		end else begin
			clearMask = 16'h0001 << s_r.pos;
		end
		origBit = |(memRdata & clearMask);
	end

	assign accept = instrValid && instrReady;

	// Handshake and memory request valid come straight from the state; data fields are registered.
	always_comb begin
		instrReady = (s_r.st == branch_unit_pkg::ST_IDLE);
		rmwLock = (s_r.st != branch_unit_pkg::ST_IDLE);
		memReq.valid = (s_r.st != branch_unit_pkg::ST_IDLE);
		memReq.write = (s_r.st == branch_unit_pkg::ST_WRITE);
		memReq.byteOp = s_r.isByte;
		memReq.addr = s_r.addr;
		memReq.wdata = s_r.data;
		result = s_r.res;
		s_axi_awready = !s_r.awHave && !s_r.bValid;
		s_axi_wready = !s_r.wHave && !s_r.bValid;
		s_axi_bvalid = s_r.bValid;
		s_axi_bresp = s_r.bResp;
		s_axi_arready = !s_r.rValid;
		s_axi_rvalid = s_r.rValid;
		s_axi_rdata = s_r.rData;
		s_axi_rresp = s_r.rResp;
	end

	// Next-state logic for the sequencer and the register slave.
	always_comb begin
		s_nxt = s_r;
		s_nxt.res.valid = 1'b0;
		s_nxt.res.generalFlagWe = 1'b0;
		s_nxt.res.unsupported = 1'b0;

		// Instruction sequencing. Branches finish in one cycle; the bit clear holds the lock until its write is taken.
		unique case (s_r.st)
			branch_unit_pkg::ST_IDLE: begin
				if (accept) begin
					s_nxt.seqPc = seqPc;
					unique case (instr.op)
						branch_unit_pkg::OP_BRANCH_COND, branch_unit_pkg::OP_BRANCH_ALWAYS: begin
							s_nxt.res.valid = 1'b1;
							s_nxt.res.taken = condTrue || (instr.op == branch_unit_pkg::OP_BRANCH_ALWAYS);
							if (s_nxt.res.taken) begin
								s_nxt.res.pcNext = branchTarget;
							end else begin
								s_nxt.res.pcNext = seqPc;
							end
						end
						branch_unit_pkg::OP_BRANCH_ZERO: begin
							s_nxt.res.valid = 1'b1;
							s_nxt.res.taken = zeroTaken;
							s_nxt.res.pcNext = zeroTaken ? zeroTarget : seqPc;
						end
						branch_unit_pkg::OP_BIT_CLEAR: begin
							if (instr.regPairTarget && !s_r.shortRegMode) begin
								// No bit clear on a double-length register here; software uses the double-word AND.
								s_nxt.res.valid = 1'b1;
								s_nxt.res.taken = 1'b0;
								s_nxt.res.unsupported = 1'b1;
								s_nxt.res.pcNext = seqPc;
							end else begin
								s_nxt.st = branch_unit_pkg::ST_READ;
								s_nxt.addr = instr.memAddr;
								s_nxt.isByte = instr.isByte;
								s_nxt.pos = instr.bitPos;
							end
						end
						default: begin
							s_nxt.res.valid = 1'b0;
						end
					endcase
				end
			end
			branch_unit_pkg::ST_READ: begin
				if (memAck) begin
					// Upper byte passes through untouched on byte operands.
					s_nxt.data = memRdata & ~clearMask;
					s_nxt.res.generalFlag = origBit;
					s_nxt.st = branch_unit_pkg::ST_WRITE;
				end
			end
			branch_unit_pkg::ST_WRITE: begin
				if (memAck) begin
					s_nxt.st = branch_unit_pkg::ST_IDLE;
					s_nxt.res.valid = 1'b1;
					s_nxt.res.taken = 1'b0;
					s_nxt.res.pcNext = s_r.seqPc;
					s_nxt.res.generalFlagWe = 1'b1;
				end
			end
		endcase

		// Status bookkeeping for software.
		if (s_nxt.res.valid) begin
			s_nxt.lastTaken = s_nxt.res.taken;
			s_nxt.lastUnsup = s_nxt.res.unsupported;
		end

		// Write channel: address and data are caught in either order, then committed together.
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.awHave = 1'b1;
			// An address above the map is parked as a misaligned offset, so it still decodes as off the map.
			s_nxt.awAddr = ((s_axi_awaddr >> 4) != '0) ? 4'h1 : 4'(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.wHave = 1'b1;
			s_nxt.wData = s_axi_wdata;
			s_nxt.wStrb = s_axi_wstrb;
		end
		if (s_r.awHave && s_r.wHave) begin
			s_nxt.awHave = 1'b0;
			s_nxt.wHave = 1'b0;
			s_nxt.bValid = 1'b1;
			s_nxt.bResp = `RESP_OKAY;
			unique case (decodeAddr(ADDR_W'(s_r.awAddr)))
				SEL_CTRL: begin
					if (s_r.wStrb[0]) begin
						s_nxt.shortRegMode = s_r.wData[`CTRL_SHORT_REG_BIT];
					end
				end
				SEL_TAKEN_CNT: begin
					// Any write clears the counter; a taken branch in the same cycle still counts.
					s_nxt.takenCnt = 16'h0000;
				end
				SEL_STATUS, SEL_LAST_PC: begin
					s_nxt.bResp = `RESP_OKAY;
				end
				default: begin
					s_nxt.bResp = `RESP_SLVERR;
				end
			endcase
		end
		if (s_r.bValid && s_axi_bready) begin
			s_nxt.bValid = 1'b0;
		end
		if (s_r.res.valid && s_r.res.taken) begin
			s_nxt.takenCnt = s_nxt.takenCnt + 16'h0001;
		end

		// Read channel: one cycle from address to data.
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rValid = 1'b1;
			s_nxt.rResp = `RESP_OKAY;
			s_nxt.rData = 32'h00000000;
			unique case (decodeAddr(s_axi_araddr))
				SEL_CTRL: s_nxt.rData[`CTRL_SHORT_REG_BIT] = s_r.shortRegMode;
				SEL_STATUS: begin
					s_nxt.rData[`STAT_BUSY_BIT] = (s_r.st != branch_unit_pkg::ST_IDLE);
					s_nxt.rData[`STAT_TAKEN_BIT] = s_r.lastTaken;
					s_nxt.rData[`STAT_GFLAG_BIT] = s_r.res.generalFlag;
					s_nxt.rData[`STAT_UNSUP_BIT] = s_r.lastUnsup;
				end
				SEL_TAKEN_CNT: s_nxt.rData = {16'h0000, s_r.takenCnt};
				SEL_LAST_PC: s_nxt.rData = {8'h00, s_r.res.pcNext};
				default: s_nxt.rResp = `RESP_SLVERR;
			endcase
		end else if (s_r.rValid && s_axi_rready) begin
			s_nxt.rValid = 1'b0;
		end
	end

	// State register; every field takes a constant under reset.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= branch_unit_pkg::ST_IDLE;
			s_r.shortRegMode <= `CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

// File: dv/branch_unit_checker.sv
// Concurrent checks on the instruction and memory ports of the branch and bit-clear unit.
`timescale 1ns/1ns
module branch_unit_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input branch_unit_pkg::instr_s instr,
	input wire logic instrValid,
	input wire logic instrReady,
	input branch_unit_pkg::result_s result,
	input branch_unit_pkg::mem_req_s memReq,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	input wire logic rmwLock
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [15:0] readSeen;
	wire logic take = instrValid && instrReady;
	wire logic isClr = instr.op == branch_unit_pkg::OP_BIT_CLEAR;
	wire logic rdAck = memReq.valid && !memReq.write && memAck;
	// The data line is sampled every cycle, so one cycle after a read ack the write-back can be compared with what was read.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readSeen <= 16'h0;
		end else begin
			readSeen <= memRdata;
		end
	end
	branch_quick_a: assert property (take && !isClr |=> result.valid) else $error("branch result late");
	always_taken_a: assert property (take && instr.op == branch_unit_pkg::OP_BRANCH_ALWAYS |=> result.taken)
		else $error("unconditional branch not taken");
	not_taken_a: assert property (take && !isClr |=> result.taken ||
		result.pcNext == 24'($past(instr.pc) + $past(instr.instLen))) else $error("sequential address wrong");
	zero_fwd_a: assert property (take && instr.op == branch_unit_pkg::OP_BRANCH_ZERO |=> !result.taken ||
		result.pcNext == 24'($past(instr.pc) + {$past(instr.zeroDispField) + 5'h1, 1'b0}))
		else $error("zero compare target wrong");
	lock_held_a: assert property (memReq.valid |-> rmwLock && !instrReady) else $error("access not locked");
	addr_hold_a: assert property (memReq.valid && !memAck |=> memReq.valid && $stable(memReq.addr) &&
		$stable(memReq.write)) else $error("memory request changed before ack");
	rmw_pair_a: assert property (rdAck |=> memReq.valid && memReq.write && memReq.addr == $past(memReq.addr))
		else $error("write-back missing");
	one_bit_a: assert property (rdAck |=> $countones(memReq.wdata ^ readSeen) <= 1 &&
		(memReq.wdata & ~readSeen) == 16'h0) else $error("more than one bit changed");
	byte_keep_a: assert property (rdAck && memReq.byteOp |=> memReq.wdata[15:8] == readSeen[15:8])
		else $error("upper byte changed");
	flag_done_a: assert property (memReq.valid && memReq.write && memAck |=>
		result.valid && result.generalFlagWe && !result.taken) else $error("bit clear completion wrong");
	unsup_a: assert property (result.unsupported |-> result.valid && !result.generalFlagWe)
		else $error("unsupported report wrong");
endmodule

// File: dv/test_branch_condition_bit_clear_unit.sv
// Self-checking bench for the branch and bit-clear unit.
`timescale 1ns/1ns
module test_branch_condition_bit_clear_unit;
	logic ref_clk = 1'b0, rst = 1'b1;
	logic [4:0] awAddr = 5'h0, arAddr = 5'h0;
	logic [31:0] wData = 32'h0, rData;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, instrReady, rmwLock;
	logic [1:0] bResp, rResp;
	branch_unit_pkg::instr_s instr = '0;
	branch_unit_pkg::flags_s flags = '0;
	branch_unit_pkg::result_s result;
	branch_unit_pkg::mem_req_s memReq;
	logic instrValid = 1'b0, memAck = 1'b0;
	logic [15:0] memRdata = 16'h0, memWord = 16'h0, memSeed = 16'h0;
	int seedCount = 0, seedSeen = 0;
	logic [1:0] memWait = 2'h0;
	int failures = 0, samplesChecked = 0, cycles = 0;
	branch_condition_bit_clear_unit #(.ADDR_W(5)) i_branch_condition_bit_clear_unit (.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .instr(instr), .instrValid(instrValid), .instrReady(instrReady), .flags(flags),
		.result(result), .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .rmwLock(rmwLock));
	// Clock and a cycle ceiling so that a hung handshake still ends the run.
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	// Memory answers after a three-cycle stall; the data line shows the inverse outside an ack.
	always @(posedge ref_clk) begin
		memAck <= 1'b0;
		memRdata <= ~memWord;
		if (memReq.valid && !memAck) begin
			memWait <= memWait + 2'h1;
			if (memWait == 2'h2) begin
				memAck <= 1'b1;
				memRdata <= memWord;
				memWait <= 2'h0;
			end
		end
		// A new seed from a scenario replaces the word; only this process ever writes it.
		if (seedCount != seedSeen) begin
			memWord <= memSeed;
			seedSeen <= seedCount;
		end else if (memReq.valid && memReq.write && memAck) begin
			memWord <= memReq.wdata;
		end
	end
	task automatic tally_and_finish();
		if (failures == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Address and data are offered together; each is dropped after its own handshake edge.
	task automatic axiWrite(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		@(posedge ref_clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(negedge ref_clk);
			ta = awValid && awReady;
			tw = wValid && wReady;
			@(posedge ref_clk);
			if (ta) awValid <= 1'b0;
			if (tw) wValid <= 1'b0;
		end while ((awValid && !ta) || (wValid && !tw));
		do @(negedge ref_clk); while (!bValid);
		check(bResp, er);
		@(posedge ref_clk);
		bReady <= 1'b0;
	endtask
	task automatic axiRead(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge ref_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do @(negedge ref_clk); while (!arReady);
		@(posedge ref_clk);
		arValid <= 1'b0;
		do @(negedge ref_clk); while (!rValid);
		check(rData, ed);
		check(rResp, er);
		@(posedge ref_clk);
		rReady <= 1'b0;
	endtask
	// Hands one instruction over and returns once its result is showing.
	task automatic issue(input branch_unit_pkg::instr_s i, input branch_unit_pkg::flags_s f);
		@(posedge ref_clk);
		instr <= i;
		flags <= f;
		instrValid <= 1'b1;
		do @(negedge ref_clk); while (!instrReady);
		@(posedge ref_clk);
		instrValid <= 1'b0;
		do @(negedge ref_clk); while (!result.valid);
	endtask
	function automatic logic condExp(input logic [3:0] c, input branch_unit_pkg::flags_s f);
		logic [15:0] t;
		t = {1'b0, 1'b1, f.zeroFlag | f.negativeFlag, !f.zeroFlag && !f.negativeFlag, f.zeroFlag | f.lowFlag,
			!f.zeroFlag && !f.lowFlag, !f.generalFlag, f.generalFlag, !f.negativeFlag, f.negativeFlag,
			!f.lowFlag, f.lowFlag, !f.carryFlag, f.carryFlag, !f.zeroFlag, f.zeroFlag};
		return t[c];
	endfunction
	// Every condition code under every flag state, all three displacement sizes, both signs.
	task automatic condTest();
		branch_unit_pkg::instr_s i;
		logic [23:0] d;
		logic tk;
		for (int c = 0; c < 16; c++) begin
			for (int f = 0; f < 32; f++) begin
				i = '0;
				i.op = c == 15 ? branch_unit_pkg::OP_BRANCH_ALWAYS : branch_unit_pkg::OP_BRANCH_COND;
				i.cond = branch_unit_pkg::cond_e'(4'(c));
				i.dispSize = branch_unit_pkg::disp_e'(2'(c % 3));
				i.dispField = f % 2 ? 24'h0b4b4b : 24'hb4b4b4;
				i.pc = 24'h009ff0;
				i.instLen = 3'h4;
				d = i.dispField;
				if (c % 3 == 0) d = {{16{d[7]}}, d[7:0]};
				if (c % 3 == 1) d = {{8{d[15]}}, d[15:0]};
				tk = c == 15 || condExp(4'(c), branch_unit_pkg::flags_s'(5'(f)));
				issue(i, branch_unit_pkg::flags_s'(5'(f)));
				check(result.taken, tk);
				check(result.pcNext, tk ? 24'(i.pc + {d[22:0], 1'b0}) : 24'(i.pc + i.instLen));
			end
		end
	endtask
	// Both forms and both widths, with upper-byte-only values that a word compare sees.
	task automatic zeroTest();
		branch_unit_pkg::instr_s i;
		logic [15:0] vals [4] = '{16'h0000, 16'hff00, 16'h0001, 16'h0100};
		logic z;
		for (int k = 0; k < 16; k++) begin
			i = '0;
			i.op = branch_unit_pkg::OP_BRANCH_ZERO;
			i.isByte = k[0];
			i.zeroEqForm = k[1];
			i.regVal = vals[k / 4];
			i.zeroDispField = 4'(k * 5);
			i.pc = 24'hfffff0;
			i.instLen = 3'h2;
			z = i.isByte ? i.regVal[7:0] == 8'h0 : i.regVal == 16'h0;
			issue(i, '0);
			check(result.taken, i.zeroEqForm ? z : !z);
			check(result.pcNext, (i.zeroEqForm ? z : !z) ? 24'(i.pc + {i.zeroDispField + 5'h1, 1'b0}) : 24'hfffff2);
		end
	endtask
	// Bit clears of byte and word operands, then the register-pair target in both modes.
	task automatic clearTest();
		branch_unit_pkg::instr_s i;
		logic [15:0] orig [5] = '{16'h007f, 16'hf5e7, 16'h009f, 16'h3c5a, 16'h8000};
		logic [15:0] want [5] = '{16'h005f, 16'hf4e7, 16'h0097, 16'h3c5a, 16'h0000};
		logic [4:0] pos [5] = '{5'h5, 5'h8, 5'h3, 5'h9, 5'hf};
		for (int k = 0; k < 6; k++) begin
			i = '0;
			i.op = branch_unit_pkg::OP_BIT_CLEAR;
			i.isByte = k != 1 && k != 4;
			i.bitPos = k < 5 ? pos[k][3:0] : 4'h0;
			i.memAddr = 24'h002009;
			i.regPairTarget = k == 5;
			memSeed <= k < 5 ? orig[k] : 16'h0001;
			seedCount <= seedCount + 1;
			issue(i, '0);
			check(memWord, k < 5 ? want[k] : 16'h0001);
			check(result.generalFlag && !result.unsupported, k != 3 && k != 5);
			check(result.unsupported, k == 5);
		end
		axiWrite(5'h00, 32'h1, 2'b00);
		axiRead(5'h00, 32'h1, 2'b00);
		issue(i, '0);
		check(memWord, 16'h0000);
		check(result.unsupported, 1'b0);
		axiRead(5'h04, 32'h4, 2'b00);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		condTest();
		zeroTest();
		// Taken branches so far: 288 from the condition sweep and 8 from the zero compares.
		axiRead(5'h08, 32'h00000128, 2'b00);
		clearTest();
		axiWrite(5'h08, 32'h0, 2'b00);
		axiRead(5'h08, 32'h0, 2'b00);
		axiRead(5'h10, 32'h0, 2'b10);
		axiWrite(5'h14, 32'h1, 2'b10);
		tally_and_finish();
	end
endmodule
bind branch_condition_bit_clear_unit branch_unit_checker i_branch_unit_checker (.ref_clk(ref_clk), .rst(rst),
	.instr(instr), .instrValid(instrValid), .instrReady(instrReady), .result(result), .memReq(memReq),
	.memAck(memAck), .memRdata(memRdata), .rmwLock(rmwLock));
